// ==== src/rlcmd_defines.svh ====
// Constants for the remote/local limit command handler
`ifndef RLCMD_DEFINES_SVH
`define RLCMD_DEFINES_SVH
// Power-on control state codes
`define RLCMD_PON_PANEL      2'h0
`define RLCMD_PON_AUTO       2'h1
`define RLCMD_PON_REMOTE     2'h2
// Factory default power-on state
`define RLCMD_PON_FACTORY    2'h1
// Device status word bit positions
`define RLCMD_STAT_REMOTE    4
`define RLCMD_STAT_LOCAL     5
`define RLCMD_STAT_LOCKOUT   6
`define RLCMD_STAT_WIDTH     16
// Output button hold time before handing control back
`define RLCMD_HOLD_MS        1000
`define RLCMD_CLK_HZ         20000000
`define RLCMD_HOLD_CYCLES    ((`RLCMD_CLK_HZ / 1000) * `RLCMD_HOLD_MS)
`endif

// ==== src/rlcmd_pkg.sv ====
// Types for the remote/local limit command handler
package rlcmd_pkg;
  // Decoded command codes
  typedef enum logic [3:0] {
    RLCMD_NONE,
    RLCMD_POWER_CEILING_QUERY,
    RLCMD_RESISTANCE_SPAN_QUERY,
    RLCMD_RESISTANCE_UPPER_QUERY,
    RLCMD_RESISTANCE_LOWER_QUERY,
    RLCMD_VOLTAGE_CEILING_QUERY,
    RLCMD_CLEAR_STATUS_COMMAND,
    RLCMD_DEVICE_CLEAR_COMMAND,
    RLCMD_GO_LOCAL_COMMAND,
    RLCMD_GO_REMOTE_COMMAND,
    RLCMD_KEYPAD_LOCKOUT,
    RLCMD_INSTRUMENT_RESET_COMMAND,
    RLCMD_STATUS_QUERY,
    RLCMD_OTHER
  } rlcmd_code_type;

  // One command from the parser
  typedef struct packed {
    rlcmd_code_type code;       // Command
    logic           has_param;  // Parameter present
    logic [1:0]     param;      // Numeric parameter
  } rlcmd_cmd_type;

  // Stored user ceilings (fixed-point, parser formats them)
  typedef struct packed {
    logic [31:0] power;
    logic [31:0] voltage;
    logic [31:0] res_min;
    logic [31:0] res_max;
  } rlcmd_limits_type;

  // Reply descriptor
  typedef struct packed {
    rlcmd_code_type code;       // Echoed command name
    logic [1:0]     count;      // Number of values
    logic           skip_first; // First field empty
    logic [31:0]    value0;
    logic [31:0]    value1;
  } rlcmd_reply_type;
endpackage

// ==== src/rlcmd_hold_timer.sv ====
// Hold timer that pulses once a level has stood for a set number of cycles
`timescale 1ns/100ps
module rlcmd_hold_timer #(
  parameter int unsigned CYCLES = 20000000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level in, pulse out
  input  wire logic level_i,
  output logic      done_o
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count_reg; // Cycles the level has stood
  logic         fired_reg; // Already pulsed for this hold

  // Count while held, restart on release
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !level_i)
    begin
      count_reg <= '0;
      fired_reg <= 1'b0;
      done_o    <= 1'b0;
    end
    else if (count_reg >= W'(CYCLES))
    begin
      done_o    <= !fired_reg;
      fired_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + W'(1);
      done_o    <= 1'b0;
    end
  end
endmodule

// ==== src/rlcmd_handler.sv ====
// Command handler for limit, status and remote/local commands
//
// Behaviour
// - Power query echoes name plus watt ceiling
// - Limit replies report stored user ceilings
// - Span query replies minimum then maximum ohms
// - Upper query replies maximum resistance only
// - Lower query replies minimum resistance only
// - Voltage query echoes name plus volt ceiling
// - Clear status clears byte, no reply
// - Device clear acts like instrument reset
// - Device clear also resets the interface
// - Go local hands control to panel
// - Go local cancels any lockout
// - Go remote enables remote, parameter stores state
// - Go remote without parameter keeps state
// - State 0 starts local, needs go remote
// - Factory default power-on state is 1
// - State 2 starts remote with lockout
// - Lockout stops keypad leaving remote
// - Held output button returns local unless locked
// - Instrument reset restores power-on, no reply
// - Status query replies binary status word
// - Status bit 6 shows lockout
// - Status bit 4 remote, bit 5 local
`timescale 1ns/100ps
`include "rlcmd_defines.svh"
module rlcmd_handler #(
  parameter int unsigned HOLD_CYCLES = `RLCMD_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Command from parser
  input  wire logic                       cmd_valid_i,
  input  wire rlcmd_pkg::rlcmd_cmd_type   cmd_i,
  // Stored user ceilings and other status inputs
  input  wire rlcmd_pkg::rlcmd_limits_type limits_i,
  input  wire logic [15:0]                hw_status_i,
  // Non-volatile power-on state
  input  wire logic [1:0]                 pon_stored_i,
  input  wire logic                       pon_stored_valid_i,
  // Front-panel output button (pin)
  input  wire logic                       output_button_i,
  // Reply to parser
  output logic                            reply_valid_o,
  output rlcmd_pkg::rlcmd_reply_type      reply_o,
  // Remote/local state
  output logic                            remote_o,
  output logic                            lockout_o,
  output logic [1:0]                      pon_state_o,
  output logic                            pon_write_o,
  // Status byte clear and reset strobes
  output logic                            stb_clear_o,
  output logic                            settings_reset_o,
  output logic                            interface_reset_o
);
  import rlcmd_pkg::*;

  logic       btn_meta_reg;   // Synchroniser stage one
  logic       btn_sync_reg;   // Synchroniser stage two
  logic       hold_done;      // Button held long enough
  logic       boot_reg;       // Power-on state still to be applied
  logic       is_reset_cmd;   // Device clear or instrument reset
  logic [15:0] status_word;   // Device status word

  // Button synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
    end
    else
    begin
      btn_meta_reg <= output_button_i;
      btn_sync_reg <= btn_meta_reg;
    end
  end

  // Hold timer on the synchronised button
  rlcmd_hold_timer #(
    .CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (btn_sync_reg),
    .done_o  (hold_done)
  );

  // Reset commands restore power-on state
  assign is_reset_cmd = cmd_valid_i &&
                        (cmd_i.code == RLCMD_DEVICE_CLEAR_COMMAND ||
                         cmd_i.code == RLCMD_INSTRUMENT_RESET_COMMAND);

  // Power-on state held; loaded from storage once, factory value otherwise
  always_ff @(posedge clk_i)
  begin
    pon_write_o <= 1'b0;
    if (rst_i)
    begin
      pon_state_o <= `RLCMD_PON_FACTORY;
      boot_reg    <= 1'b1;
    end
    else if (cmd_valid_i && cmd_i.code == RLCMD_GO_REMOTE_COMMAND && cmd_i.has_param
             && cmd_i.param != 2'h3)
    begin
      // Store the state chosen for the next power cycle
      pon_state_o <= cmd_i.param;
      pon_write_o <= 1'b1;
      boot_reg    <= 1'b0;
    end
    else if (boot_reg && pon_stored_valid_i && pon_stored_i != 2'h3)
    begin
      // Take the stored value at start-up
      pon_state_o <= pon_stored_i;
      boot_reg    <= 1'b0;
    end
    else
    begin
      // Parameterless go remote leaves the state alone
      boot_reg <= 1'b0;
    end
  end

  // Remote and lockout state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remote_o  <= 1'b0;
      lockout_o <= 1'b0;
    end
    else if (boot_reg || is_reset_cmd)
    begin
      // Apply power-on control state (stored value on boot)
      if ((boot_reg && pon_stored_valid_i ? pon_stored_i : pon_state_o)
          == `RLCMD_PON_REMOTE)
      begin
        remote_o  <= 1'b1;
        lockout_o <= 1'b1;
      end
      else
      begin
        // States 0 and 1 start under front-panel control
        remote_o  <= 1'b0;
        lockout_o <= 1'b0;
      end
    end
    else if (cmd_valid_i)
    begin
      unique case (cmd_i.code)
        RLCMD_GO_LOCAL_COMMAND:
        begin
          remote_o  <= 1'b0;
          lockout_o <= 1'b0;
        end
        RLCMD_GO_REMOTE_COMMAND:
        begin
          remote_o <= 1'b1;
        end
        RLCMD_KEYPAD_LOCKOUT:
        begin
          lockout_o <= 1'b1;
        end
        default:
        begin
          // In auto state any other command takes remote with lockout
          if (!remote_o && pon_state_o == `RLCMD_PON_AUTO)
          begin
            remote_o  <= 1'b1;
            lockout_o <= 1'b1;
          end
        end
      endcase
    end
    else if (hold_done && remote_o && !lockout_o)
    begin
      // Long press hands control back while not locked
      remote_o <= 1'b0;
    end
  end

  // Status word assembly
  always_comb
  begin
    status_word = hw_status_i;
    status_word[`RLCMD_STAT_LOCKOUT] = lockout_o;
    status_word[`RLCMD_STAT_REMOTE]  = remote_o;
    status_word[`RLCMD_STAT_LOCAL]   = !remote_o;
  end

  // Status byte clear and reset strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stb_clear_o       <= 1'b0;
      settings_reset_o  <= 1'b0;
      interface_reset_o <= 1'b0;
    end
    else
    begin
      stb_clear_o       <= cmd_valid_i && cmd_i.code == RLCMD_CLEAR_STATUS_COMMAND;
      settings_reset_o  <= is_reset_cmd;
      interface_reset_o <= cmd_valid_i &&
                           cmd_i.code == RLCMD_DEVICE_CLEAR_COMMAND;
    end
  end

  // Replies to queries; action commands produce none
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reply_valid_o <= 1'b0;
      reply_o       <= '0;
    end
    else
    begin
      reply_valid_o      <= 1'b0;
      reply_o.skip_first <= 1'b0;
      reply_o.value1     <= 32'h0000_0000;
      if (cmd_valid_i)
      begin
        reply_o.code <= cmd_i.code;
        unique case (cmd_i.code)
          RLCMD_POWER_CEILING_QUERY:
          begin
            reply_valid_o  <= 1'b1;
            reply_o.count  <= 2'h1;
            reply_o.value0 <= limits_i.power;
          end
          RLCMD_RESISTANCE_SPAN_QUERY:
          begin
            reply_valid_o  <= 1'b1;
            reply_o.count  <= 2'h2;
            reply_o.value0 <= limits_i.res_min;
            reply_o.value1 <= limits_i.res_max;
          end
          RLCMD_RESISTANCE_UPPER_QUERY:
          begin
            reply_valid_o      <= 1'b1;
            reply_o.count      <= 2'h1;
            reply_o.skip_first <= 1'b1;
            reply_o.value0     <= limits_i.res_max;
          end
          RLCMD_RESISTANCE_LOWER_QUERY:
          begin
            reply_valid_o  <= 1'b1;
            reply_o.count  <= 2'h1;
            reply_o.value0 <= limits_i.res_min;
          end
          RLCMD_VOLTAGE_CEILING_QUERY:
          begin
            reply_valid_o  <= 1'b1;
            reply_o.count  <= 2'h1;
            reply_o.value0 <= limits_i.voltage;
          end
          RLCMD_STATUS_QUERY:
          begin
            // Parser prints value0 low 16 bits as binary digits
            reply_valid_o  <= 1'b1;
            reply_o.count  <= 2'h1;
            reply_o.value0 <= {16'h0000, status_word};
          end
          default:
          begin
            reply_o.count <= 2'h0; // No reply
          end
        endcase
      end
    end
  end
endmodule

// ==== test/rlcmd_handler_props.sv ====
// Port checker for the command handler
`timescale 1ns/100ps
module rlcmd_handler_props (
  // Clock and reset
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  // Command taken
  input wire logic                     cmd_valid_i,
  input wire rlcmd_pkg::rlcmd_cmd_type cmd_i,
  // Outputs watched
  input wire logic                     reply_valid_o,
  input wire logic                     remote_o,
  input wire logic                     lockout_o,
  input wire logic [1:0]               pon_state_o,
  input wire logic                     pon_write_o,
  input wire logic                     stb_clear_o,
  input wire logic                     settings_reset_o,
  input wire logic                     interface_reset_o
);
  import rlcmd_pkg::*;
  logic        run_reg; // Low in the boot cycle
  logic [15:0] hit;     // One bit per command code taken
  // Remote and lockout logic ignores commands in the boot cycle, so mask them out here
  always_ff @(posedge clk_i)
  begin
    run_reg <= !rst_i;
  end
  assign hit = (cmd_valid_i && run_reg) ? (16'h0001 << cmd_i.code) : 16'h0000;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_clear_quiet: assert property (hit[6] |=> stb_clear_o && !reply_valid_o)
    else $error("clear status misbehaved");
  a_device_clear: assert property (hit[7] |=> settings_reset_o && interface_reset_o)
    else $error("device clear missed a strobe");
  a_reset_quiet: assert property (hit[11] |=> settings_reset_o && !reply_valid_o)
    else $error("instrument reset misbehaved");
  a_local_free: assert property (hit[8] |=> !remote_o && !lockout_o)
    else $error("go local left remote or lockout");
  a_remote_param: assert property (hit[9] && cmd_i.has_param && cmd_i.param != 2'h3
    |=> remote_o && pon_write_o && pon_state_o == $past(cmd_i.param))
    else $error("go remote with state failed");
  a_remote_keep: assert property (hit[9] && !cmd_i.has_param
    |=> remote_o && !pon_write_o && $stable(pon_state_o))
    else $error("go remote changed stored state");
  a_lockout_set: assert property (hit[10] |=> lockout_o)
    else $error("lockout not set");
  a_auto_lock: assert property (hit[6] && !remote_o && pon_state_o == 2'h1
    |=> remote_o && lockout_o)
    else $error("auto state did not lock");
endmodule
bind rlcmd_handler rlcmd_handler_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .reply_valid_o(reply_valid_o), .remote_o(remote_o), .lockout_o(lockout_o),
  .pon_state_o(pon_state_o), .pon_write_o(pon_write_o), .stb_clear_o(stb_clear_o),
  .settings_reset_o(settings_reset_o), .interface_reset_o(interface_reset_o)
);

// ==== test/rlcmd_host_model.sv ====
// Host model that hands parsed commands to the handler
`timescale 1ns/100ps
module rlcmd_host_model (
  // Clock
  input  wire logic                clk_i,
  // Command out
  output rlcmd_pkg::rlcmd_cmd_type cmd_o,
  output logic                     cmd_valid_o
);
  import rlcmd_pkg::*;
  // Idle at start
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // One command for one cycle; fields inverted after so stale values never match
  task automatic send(input rlcmd_code_type c, input logic h, input logic [1:0] p);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = '{c, h, p};
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = rlcmd_cmd_type'(~cmd_o);
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the command handler
`timescale 1ns/100ps
module tb_top;
  import rlcmd_pkg::*;
  localparam int unsigned HOLD = 20; // Short button hold count
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cmd_valid_i;
  rlcmd_cmd_type    cmd_i;
  rlcmd_limits_type limits_i = '0;
  logic [15:0]      hw_status_i = 16'h0000;
  logic [1:0]       pon_stored_i = 2'h0;
  logic             pon_stored_valid_i = 1'b0;
  logic             output_button_i = 1'b0;
  logic             reply_valid_o;
  rlcmd_reply_type  reply_o;
  logic             remote_o;
  logic             lockout_o;
  logic [1:0]       pon_state_o;
  logic             pon_write_o;
  logic             stb_clear_o;
  logic             settings_reset_o;
  logic             interface_reset_o;
  int               fails = 0;
  int               samples_checked = 0;
  int unsigned      n;
  rlcmd_code_type   q;
  rlcmd_host_model u_host (.clk_i(clk_i), .cmd_o(cmd_i), .cmd_valid_o(cmd_valid_i));
  rlcmd_handler #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .limits_i(limits_i), .hw_status_i(hw_status_i), .pon_stored_i(pon_stored_i),
    .pon_stored_valid_i(pon_stored_valid_i), .output_button_i(output_button_i),
    .reply_valid_o(reply_valid_o), .reply_o(reply_o), .remote_o(remote_o),
    .lockout_o(lockout_o), .pon_state_o(pon_state_o), .pon_write_o(pon_write_o),
    .stb_clear_o(stb_clear_o), .settings_reset_o(settings_reset_o),
    .interface_reset_o(interface_reset_o)
  );
  // Clock at 50 ns period
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Send one command; it returns in the cycle where its one-cycle answer stands
  task automatic cmd(input rlcmd_code_type c, input logic h = 1'b0, input logic [1:0] p = 2'h0);
    u_host.send(c, h, p);
  endtask
  // Hold the output button; drop says whether remote must fall
  task automatic press(input logic drop);
    int k;
    output_button_i = 1'b1;
    for (k = 0; k < HOLD + 10 && remote_o !== 1'b0; k++) @(negedge clk_i);
    output_button_i = 1'b0;
    chk(remote_o, !drop);
    if (drop) chk(k >= HOLD, 1'b1);
    if (drop && k == HOLD + 10) give_verdict();
  endtask
  // Value expected in the first reply field
  function automatic logic [31:0] exp_v0(input rlcmd_code_type c);
    case (c)
      RLCMD_POWER_CEILING_QUERY:    return limits_i.power;
      RLCMD_VOLTAGE_CEILING_QUERY:  return limits_i.voltage;
      RLCMD_RESISTANCE_UPPER_QUERY: return limits_i.res_max;
      default:                      return limits_i.res_min;
    endcase
  endfunction
  // Main sequence
  initial
  begin
    n = $urandom(32'hD1FF2026);
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({remote_o, pon_state_o}, 3'h1);
    cmd(RLCMD_CLEAR_STATUS_COMMAND);
    chk({stb_clear_o, reply_valid_o, remote_o, lockout_o}, 4'hB);
    hw_status_i = 16'($urandom);
    cmd(RLCMD_STATUS_QUERY);
    chk(reply_o.value0[15:0], {hw_status_i[15:7], 3'b101, hw_status_i[3:0]});
    $display("test auto state ended");
    for (int i = 0; i < 10; i++)
    begin
      q = rlcmd_code_type'(1 + i % 5);
      limits_i = {$urandom, $urandom, $urandom, $urandom};
      cmd(q);
      chk({reply_valid_o, reply_o.code}, {1'b1, q});
      chk(reply_o.value0, exp_v0(q));
      chk(reply_o.skip_first, q == RLCMD_RESISTANCE_UPPER_QUERY);
      chk(reply_o.count, (q == RLCMD_RESISTANCE_SPAN_QUERY) ? 2'h2 : 2'h1);
      if (q == RLCMD_RESISTANCE_SPAN_QUERY) chk(reply_o.value1, limits_i.res_max);
    end
    $display("test limits ended");
    press(1'b0);
    cmd(RLCMD_GO_LOCAL_COMMAND);
    chk({remote_o, lockout_o}, 2'h0);
    cmd(RLCMD_GO_REMOTE_COMMAND);
    chk({remote_o, lockout_o, pon_state_o}, 4'h9);
    press(1'b1);
    cmd(RLCMD_GO_REMOTE_COMMAND, 1'b1, 2'h0);
    chk({pon_write_o, pon_state_o}, 3'h4);
    cmd(RLCMD_DEVICE_CLEAR_COMMAND);
    chk({settings_reset_o, interface_reset_o, remote_o}, 3'h6);
    cmd(RLCMD_CLEAR_STATUS_COMMAND);
    chk(remote_o, 1'b0);
    cmd(RLCMD_GO_REMOTE_COMMAND, 1'b1, 2'h2);
    cmd(RLCMD_KEYPAD_LOCKOUT);
    cmd(RLCMD_INSTRUMENT_RESET_COMMAND);
    chk({settings_reset_o, reply_valid_o, remote_o, lockout_o}, 4'hB);
    $display("test remote local ended");
    rst_i = 1'b1;
    pon_stored_i = 2'h2;
    pon_stored_valid_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({remote_o, lockout_o, pon_state_o}, 4'hE);
    $display("test boot remote ended");
    give_verdict();
  end
endmodule
